// *** shared/duart_port_consts.svh ***
// Named constants for the host port, interrupt and input port block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DUART_PORT_CONSTS_SVH
`define DUART_PORT_CONSTS_SVH

// Clock and change-detector filter timing
`define CLK_PERIOD_NS     5
`define CHG_FILTER_NS     25000
`define CHG_CNT_W         16

// Register select codes, read side
`define RD_STATUS_A       4'h1
`define RD_INPUT_CHANGE   4'h4
`define RD_IRQ_STATUS     4'h5
`define RD_STATUS_B       4'h9
`define RD_INPUT_PORT     4'hD
`define RD_CTR_START      4'hE
`define RD_CTR_STOP       4'hF

// Register select codes, write side
`define WR_CMD_A          4'h2
`define WR_AUX_CTRL       4'h4
`define WR_IRQ_MASK       4'h5
`define WR_CLK_SEL_B      4'h9
`define WR_CMD_B          4'hA
`define WR_OUT_CONFIG     4'hD
`define WR_OUT_SET        4'hE
`define WR_OUT_CLEAR      4'hF

// Reset values
`define RST_BYTE          8'h00
`define RST_NIBBLE        4'h0
`define RST_OUT_PINS      8'hFF

// Interrupt status bit positions
`define ISR_TX_A          0
`define ISR_RX_A          1
`define ISR_BRK_A         2
`define ISR_CTR           3
`define ISR_TX_B          4
`define ISR_RX_B          5
`define ISR_BRK_B         6
`define ISR_IN_CHG        7

// Command register fields
`define CMD_TX_ON         2
`define CMD_TX_OFF        3

// Auxiliary control fields
`define ACR_CTR_EXT_CLK   4

// Output configuration fields
`define OUTPUT_PORT_CONFIG_REG_OP3_CTR      2
`define OUTPUT_PORT_CONFIG_REG_OP4_RX_A     4
`define OUTPUT_PORT_CONFIG_REG_OP5_RX_B     5
`define OUTPUT_PORT_CONFIG_REG_OP6_TX_A     6
`define OUTPUT_PORT_CONFIG_REG_OP7_TX_B     7

// Clock select value for external receive clock on channel B
`define CSRB_RX_EXT       4'hE

// Pin bundle layout after synchronisation
`define SYNC_W            23
`endif

// *** shared/duart_port_pkg.sv ***
// Types shared by the host port block, its bus model and its bench.
// Assumes the constants header sits beside it on the include path.
`default_nettype none
`include "duart_port_consts.svh"

package duart_port_pkg;
  // Host bus access phase
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_type;

  typedef logic [3:0] reg_sel_type;
  typedef logic [7:0] byte_type;
endpackage

`default_nettype wire

// *** logic/pin_sync.sv ***
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes every bit is a slow level; bits are not kept coherent together.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q    <= '0;
      level_out <= '0;
    end else begin
      meta_q    <= pin_in;
      level_out <= meta_q;
    end
  end
endmodule

`default_nettype wire

// *** logic/change_filter.sv ***
// Change-of-state detector with a stability filter for one input.
// Assumes a synchronised input; reports a pulse once a new level held.
`timescale 1ns/1ps
`default_nettype none
`include "duart_port_consts.svh"

module change_filter #(
  parameter int FILTER_CYCLES = 5000
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic level_in,
  output logic      stable_q,
  output logic      change_pulse
);
  logic                  primed_q;
  logic [`CHG_CNT_W-1:0] count_q;

  // Settle on the pin level after reset without flagging a change
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primed_q <= 1'b0;
      stable_q <= 1'b0;
    end else if (!primed_q) begin
      primed_q <= 1'b1;
      stable_q <= level_in;
    end else if (change_pulse) begin
      stable_q <= level_in;
    end
  end

  // Glitches shorter than the filter restart the count
  always_ff @(posedge clk) begin
    if (sys_rst || !primed_q || change_pulse || level_in == stable_q) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  assign change_pulse = primed_q && (level_in != stable_q)
                        && (count_q == `CHG_CNT_W'(FILTER_CYCLES - 1));
endmodule

`default_nettype wire

// *** logic/duart_host_port_irq_inport.sv ***
// Host port, interrupt logic and input port of a dual serial device.
// Assumes serial channels and counter live elsewhere and feed status in.
// Summary of operation
// - One active-low interrupt output, set by any of eight enabled events.
// - Interrupt mask register selects which events may assert the output.
// - Reading interrupt status returns every currently active condition.
// - Outputs three to seven may act as separate interrupt outputs.
// - Input port read returns live levels of seven inputs, high reads one.
// - Top data bit reads as one on input port reads.
// - Four change detectors watch inputs zero to three.
// - Change flagged only after the new level holds past the filter time.
// - Reading the input change register clears its change bits.
// - Any detected input change can be enabled to raise an interrupt.
// - Reset clears channel status, mask, status, output and config registers.
// - Reset drives all eight parallel outputs high and stops the counter.
// - Reset idles both channels with transmit outputs at mark level.
// - Transfers happen only while the active-low chip select is low.
// - Data lines float whenever chip select is high.
// - Write with chip select loads the bus into the selected register.
// - Write data is captured at the write strobe rising edge.
// - Read with chip select drives the selected register onto the bus.
// - Read cycle and its side effects begin at read strobe falling edge.
// - Input six serves as general input or channel B receive clock.
// - External channel B receive clock samples data on its rising edge.
// - Input two serves as general input or counter external clock.
`timescale 1ns/1ps
`default_nettype none
`include "duart_port_consts.svh"

module duart_host_port_irq_inport
  import duart_port_pkg::*;
#(
  parameter int FILTER_CYCLES = (`CHG_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      chip_select_n,
  input  wire logic                      read_strobe_n,
  input  wire logic                      write_strobe_n,
  input  wire duart_port_pkg::reg_sel_type register_select,
  input  wire duart_port_pkg::byte_type  data_in,
  output duart_port_pkg::byte_type       data_out,
  output logic                           data_oe_n,
  output logic                           irq_n,
  input  wire logic [6:0]                parallel_input_pins,
  output logic [7:0]                     parallel_output_pins,
  input  wire logic                      tx_ready_chan_a,
  input  wire logic                      rx_ready_chan_a,
  input  wire logic                      break_chg_chan_a,
  input  wire logic                      tx_ready_chan_b,
  input  wire logic                      rx_ready_chan_b,
  input  wire logic                      break_chg_chan_b,
  input  wire logic                      counter_ready,
  input  wire duart_port_pkg::byte_type  chan_status_a,
  input  wire duart_port_pkg::byte_type  chan_status_b,
  input  wire logic                      tx_bit_chan_a,
  input  wire logic                      tx_bit_chan_b,
  input  wire logic                      serial_in_chan_b,
  output logic                           serial_out_chan_a,
  output logic                           serial_out_chan_b,
  output logic [1:0]                     chan_active,
  output logic                           counter_running,
  output logic                           counter_ext_tick,
  output logic                           rx_sample_chan_b,
  output logic                           rx_bit_chan_b
);
  import duart_port_pkg::*;

  logic [`SYNC_W-1:0] sync_level;
  logic               cs_n_s;
  logic               rd_n_s;
  logic               wr_n_s;
  logic               rd_n_prev_q;
  logic               wr_n_prev_q;
  reg_sel_type        sel_s;
  byte_type           wdata_s;
  logic [6:0]         inputs_s;
  logic               rx_data_s;
  logic               aux_input_two;
  logic               aux_input_six;
  logic               aux_two_prev_q;
  logic               aux_six_prev_q;
  logic               read_fall;
  logic               write_rise;
  bus_state_type      bus_state_q;
  bus_state_type      bus_state_d;
  reg_sel_type        wsel_q;
  byte_type           wdata_q;
  logic               do_write;
  byte_type           interrupt_mask_reg_q;
  byte_type           interrupt_status_reg_q;
  byte_type           status_reg_chan_a_q;
  byte_type           status_reg_chan_b_q;
  byte_type           output_port_reg_q;
  byte_type           output_port_config_reg_q;
  byte_type           aux_ctrl_q;
  logic [3:0]         clk_sel_b_q;
  logic [3:0]         input_change_q;
  logic [3:0]         stable_level;
  logic [3:0]         change_pulse;
  logic               rx_ext_b;
  byte_type           isr_live;
  byte_type           read_mux;
  byte_type           input_port_val;
  byte_type           data_out_q;
  logic [7:0]         op_drive;

  pin_sync #(
    .WIDTH (`SYNC_W)
  ) u_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    ({serial_in_chan_b, parallel_input_pins, data_in, register_select,
                 ~write_strobe_n, ~read_strobe_n, ~chip_select_n}),
    .level_out (sync_level)
  );

  // Strobes travel inverted, so a flushed synchroniser reads as idle
  assign cs_n_s    = !sync_level[0];
  assign rd_n_s    = !sync_level[1];
  assign wr_n_s    = !sync_level[2];
  assign sel_s     = sync_level[6:3];
  assign wdata_s   = sync_level[14:7];
  assign inputs_s  = sync_level[21:15];
  assign rx_data_s = sync_level[22];
  assign aux_input_two = inputs_s[2];
  assign aux_input_six = inputs_s[6];

  // Strobe history for edge detection, reset to idle-high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_n_prev_q <= 1'b1;
      wr_n_prev_q <= 1'b1;
    end else begin
      rd_n_prev_q <= rd_n_s;
      wr_n_prev_q <= wr_n_s;
    end
  end

  assign read_fall  = rd_n_prev_q && !rd_n_s && !cs_n_s;
  assign write_rise = !wr_n_prev_q && wr_n_s;

  // Bus phase tracking; a strobe with chip select high is ignored
  always_comb begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      BUS_IDLE: begin
        if (!cs_n_s && !rd_n_s) begin
          bus_state_d = BUS_READ;
        end else if (!cs_n_s && !wr_n_s) begin
          bus_state_d = BUS_WRITE;
        end
      end
      BUS_READ: begin
        if (rd_n_s || cs_n_s) begin
          bus_state_d = BUS_IDLE;
        end
      end
      BUS_WRITE: begin
        if (wr_n_s) begin
          bus_state_d = BUS_IDLE;
        end
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_state_q <= BUS_IDLE;
    end else begin
      bus_state_q <= bus_state_d;
    end
  end

  // track select and data while chip select and the write strobe are low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wsel_q  <= `RST_NIBBLE;
      wdata_q <= `RST_BYTE;
    end else if (!cs_n_s && !wr_n_s) begin
      wsel_q  <= sel_s;
      wdata_q <= wdata_s;
    end
  end

  // Commit only writes that were opened under chip select
  assign do_write = write_rise && (bus_state_q == BUS_WRITE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_mask_reg_q <= `RST_BYTE;
    end else if (do_write && wsel_q == `WR_IRQ_MASK) begin
      interrupt_mask_reg_q <= wdata_q;
    end
  end

  // Auxiliary control and channel B clock select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_ctrl_q  <= `RST_BYTE;
      clk_sel_b_q <= `RST_NIBBLE;
    end else if (do_write && wsel_q == `WR_AUX_CTRL) begin
      aux_ctrl_q <= wdata_q;
    end else if (do_write && wsel_q == `WR_CLK_SEL_B) begin
      clk_sel_b_q <= wdata_q[7:4];
    end
  end

  // Output port register: set and clear commands by address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_port_reg_q        <= `RST_BYTE;
      output_port_config_reg_q <= `RST_BYTE;
    end else if (do_write && wsel_q == `WR_OUT_SET) begin
      output_port_reg_q <= output_port_reg_q | wdata_q;
    end else if (do_write && wsel_q == `WR_OUT_CLEAR) begin
      output_port_reg_q <= output_port_reg_q & ~wdata_q;
    end else if (do_write && wsel_q == `WR_OUT_CONFIG) begin
      output_port_config_reg_q <= wdata_q;
    end
  end

  // Channel enables from the command registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chan_active <= 2'b00;
    end else if (do_write && wsel_q == `WR_CMD_A) begin
      if (wdata_q[`CMD_TX_OFF]) begin
        chan_active[0] <= 1'b0;
      end else if (wdata_q[`CMD_TX_ON]) begin
        chan_active[0] <= 1'b1;
      end
    end else if (do_write && wsel_q == `WR_CMD_B) begin
      if (wdata_q[`CMD_TX_OFF]) begin
        chan_active[1] <= 1'b0;
      end else if (wdata_q[`CMD_TX_ON]) begin
        chan_active[1] <= 1'b1;
      end
    end
  end

  assign serial_out_chan_a = chan_active[0] ? tx_bit_chan_a : 1'b1;
  assign serial_out_chan_b = chan_active[1] ? tx_bit_chan_b : 1'b1;

  // Counter run state from address-triggered read commands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      counter_running <= 1'b0;
    end else if (read_fall && sel_s == `RD_CTR_START) begin
      counter_running <= 1'b1;
    end else if (read_fall && sel_s == `RD_CTR_STOP) begin
      counter_running <= 1'b0;
    end
  end

  // Previous levels of the auxiliary clock inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_two_prev_q <= 1'b0;
      aux_six_prev_q <= 1'b0;
    end else begin
      aux_two_prev_q <= aux_input_two;
      aux_six_prev_q <= aux_input_six;
    end
  end

  assign counter_ext_tick = aux_ctrl_q[`ACR_CTR_EXT_CLK] && aux_input_two && !aux_two_prev_q;

  assign rx_ext_b = (clk_sel_b_q == `CSRB_RX_EXT);
  assign rx_sample_chan_b = rx_ext_b && aux_input_six && !aux_six_prev_q;

  // Received bit held from the last sample point
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_bit_chan_b <= 1'b1;
    end else if (rx_sample_chan_b) begin
      rx_bit_chan_b <= rx_data_s;
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_chg
      change_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
      ) u_filter (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .level_in     (inputs_s[i]),
        .stable_q     (stable_level[i]),
        .change_pulse (change_pulse[i])
      );

      // read clears, but a new change wins
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          input_change_q[i] <= 1'b0;
        end else if (change_pulse[i]) begin
          input_change_q[i] <= 1'b1;
        end else if (read_fall && sel_s == `RD_INPUT_CHANGE) begin
          input_change_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Live interrupt sources gathered into status layout
  always_comb begin
    isr_live              = `RST_BYTE;
    isr_live[`ISR_TX_A]   = tx_ready_chan_a;
    isr_live[`ISR_RX_A]   = rx_ready_chan_a;
    isr_live[`ISR_BRK_A]  = break_chg_chan_a;
    isr_live[`ISR_CTR]    = counter_ready;
    isr_live[`ISR_TX_B]   = tx_ready_chan_b;
    isr_live[`ISR_RX_B]   = rx_ready_chan_b;
    isr_live[`ISR_BRK_B]  = break_chg_chan_b;
    isr_live[`ISR_IN_CHG] = |(input_change_q & aux_ctrl_q[3:0]);
  end

  // status follows active conditions; channel status copied while the channel is active, else zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_status_reg_q <= `RST_BYTE;
      status_reg_chan_a_q    <= `RST_BYTE;
      status_reg_chan_b_q    <= `RST_BYTE;
    end else begin
      interrupt_status_reg_q <= isr_live;
      status_reg_chan_a_q    <= chan_active[0] ? chan_status_a : `RST_BYTE;
      status_reg_chan_b_q    <= chan_active[1] ? chan_status_b : `RST_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(interrupt_status_reg_q & interrupt_mask_reg_q);
    end
  end

  // live input levels; top bit one
  assign input_port_val = {1'b1, inputs_s};

  // Read data selection; unused codes read as zero
  always_comb begin
    case (sel_s)
      `RD_STATUS_A:     read_mux = status_reg_chan_a_q;
      `RD_STATUS_B:     read_mux = status_reg_chan_b_q;
      `RD_INPUT_CHANGE: read_mux = {input_change_q, stable_level};
      `RD_IRQ_STATUS:   read_mux = interrupt_status_reg_q;
      `RD_INPUT_PORT:   read_mux = input_port_val;
      default:          read_mux = `RST_BYTE;
    endcase
  end

  // latch at read start, input port keeps tracking its pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_out_q <= `RST_BYTE;
    end else if (read_fall) begin
      data_out_q <= read_mux;
    end else if (bus_state_q == BUS_READ && sel_s == `RD_INPUT_PORT) begin
      data_out_q <= input_port_val;
    end
  end

  assign data_out = data_out_q;
  assign data_oe_n = !(bus_state_q == BUS_READ && !cs_n_s && !rd_n_s);

  // outputs three to seven as interrupt outputs, active low
  always_comb begin
    op_drive    = ~output_port_reg_q;
    op_drive[3] = output_port_config_reg_q[`OUTPUT_PORT_CONFIG_REG_OP3_CTR]
                  ? ~interrupt_status_reg_q[`ISR_CTR] : op_drive[3];
    op_drive[4] = output_port_config_reg_q[`OUTPUT_PORT_CONFIG_REG_OP4_RX_A]
                  ? ~interrupt_status_reg_q[`ISR_RX_A] : op_drive[4];
    op_drive[5] = output_port_config_reg_q[`OUTPUT_PORT_CONFIG_REG_OP5_RX_B]
                  ? ~interrupt_status_reg_q[`ISR_RX_B] : op_drive[5];
    op_drive[6] = output_port_config_reg_q[`OUTPUT_PORT_CONFIG_REG_OP6_TX_A]
                  ? ~interrupt_status_reg_q[`ISR_TX_A] : op_drive[6];
    op_drive[7] = output_port_config_reg_q[`OUTPUT_PORT_CONFIG_REG_OP7_TX_B]
                  ? ~interrupt_status_reg_q[`ISR_TX_B] : op_drive[7];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      parallel_output_pins <= `RST_OUT_PINS;
    end else begin
      parallel_output_pins <= op_drive;
    end
  end
endmodule

`default_nettype wire

// *** sim/duart_port_checker.sv ***
// Assertions on the host port block, watching its top ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module duart_port_checker #(
  parameter int FILTER_CYCLES = 5000
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       chip_select_n,
  input  wire logic       read_strobe_n,
  input  wire logic       data_oe_n,
  input  wire logic       irq_n,
  input  wire logic [6:0] parallel_input_pins,
  input  wire logic [7:0] parallel_output_pins,
  input  wire logic       serial_out_chan_a,
  input  wire logic       serial_out_chan_b,
  input  wire logic [1:0] chan_active,
  input  wire logic       counter_running,
  input  wire logic       counter_ext_tick,
  input  wire logic       rx_sample_chan_b
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pins lag two flops, hence four quiet samples
  property p_float;
    chip_select_n [*4] |-> data_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("bus driven while deselected");
  property p_no_read;
    read_strobe_n [*4] |-> data_oe_n;
  endproperty
  a_no_read: assert property (p_no_read) else $error("bus driven without read");
  property p_read_drive;
    (!read_strobe_n && !chip_select_n) [*5] |-> !data_oe_n;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
  property p_rst_irq;
    $fell(sys_rst) |-> irq_n;
  endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
  property p_rst_out;
    $fell(sys_rst) |-> parallel_output_pins == 8'hFF && !counter_running;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
  property p_rst_chan;
    $fell(sys_rst) |-> chan_active == 2'h0 && serial_out_chan_a && serial_out_chan_b;
  endproperty
  a_rst_chan: assert property (p_rst_chan) else $error("channels after reset");
  property p_mark;
    !chan_active[1] |-> serial_out_chan_b;
  endproperty
  a_mark: assert property (p_mark) else $error("idle line not at mark");
  property p_rx_low;
    !parallel_input_pins[6] [*5] |-> !rx_sample_chan_b;
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("sample without clock rise");
  property p_ext_low;
    !parallel_input_pins[2] [*5] |-> !counter_ext_tick;
  endproperty
  a_ext_low: assert property (p_ext_low) else $error("tick without clock rise");
endmodule
bind duart_host_port_irq_inport duart_port_checker #(.FILTER_CYCLES(FILTER_CYCLES)) i_chk (
  .clk, .sys_rst, .chip_select_n, .read_strobe_n, .data_oe_n, .irq_n,
  .parallel_input_pins, .parallel_output_pins, .serial_out_chan_a, .serial_out_chan_b,
  .chan_active, .counter_running, .counter_ext_tick, .rx_sample_chan_b);
`default_nettype wire

// *** sim/host_bus_model.sv ***
// Processor side of the strobe bus, with read and write tasks.
// Assumes the caller waits out reset; write strobe held four clocks.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import duart_port_pkg::*;
(
  input  wire logic                          clk,
  output var  logic                          chip_select_n,
  output var  logic                          read_strobe_n,
  output var  logic                          write_strobe_n,
  output var  duart_port_pkg::reg_sel_type   register_select,
  output var  duart_port_pkg::byte_type      data_in,
  input  wire duart_port_pkg::byte_type      data_out,
  input  wire logic                          data_oe_n
);
  // Idle bus at time zero
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    register_select = 4'h0;
    data_in = 8'h00;
  end
  // one strobe, data held past rise
  task automatic wr(input reg_sel_type s, input byte_type d, input logic cs = 1'b0);
    @(posedge clk);
    chip_select_n <= cs;
    write_strobe_n <= 1'b0;
    register_select <= s;
    data_in <= d;
    repeat (4) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    data_in <= ~d; // Released lines show no stale value
    repeat (4) @(posedge clk);
  endtask
  // read held until the device drives
  task automatic rd(input reg_sel_type s, output byte_type d);
    int n;
    n = 0;
    @(posedge clk);
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    register_select <= s;
    @(posedge clk);
    while (data_oe_n !== 1'b0 && n < 12) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    d = data_out;
    read_strobe_n <= 1'b1;
    chip_select_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** sim/tb_duart_host_port_irq_inport.sv ***
// Self-checking bench for the host port block.
// Assumes the bound checker and the bus model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "duart_port_consts.svh"
module tb_duart_host_port_irq_inport;
  import duart_port_pkg::*;
  localparam int FILT = 8;
  typedef struct packed {
    logic [6:0] src; byte_type mask; logic [6:0] pin; byte_type interrupt_status_reg; logic irq; byte_type inp;
  } row_type;
  row_type rows [8] = '{'{7'h01, 8'h00, 7'h00, 8'h01, 1'b1, 8'h80},
    '{7'h02, 8'h02, 7'h7F, 8'h02, 1'b0, 8'hFF}, '{7'h04, 8'h01, 7'h55, 8'h04, 1'b1, 8'hD5},
    '{7'h08, 8'h08, 7'h2A, 8'h08, 1'b0, 8'hAA}, '{7'h10, 8'h10, 7'h01, 8'h10, 1'b0, 8'h81},
    '{7'h20, 8'h20, 7'h40, 8'h20, 1'b0, 8'hC0}, '{7'h40, 8'h40, 7'h00, 8'h40, 1'b0, 8'h80},
    '{7'h7F, 8'h00, 7'h00, 8'h7F, 1'b1, 8'h80}};
  logic clk = 1'b0, sys_rst = 1'b1, chip_select_n, read_strobe_n, write_strobe_n, data_oe_n;
  logic irq_n, tx_ready_chan_a, rx_ready_chan_a, break_chg_chan_a, tx_ready_chan_b;
  logic rx_ready_chan_b, break_chg_chan_b, counter_ready, tx_bit_chan_a, tx_bit_chan_b;
  logic serial_in_chan_b, serial_out_chan_a, serial_out_chan_b, counter_running;
  logic counter_ext_tick, rx_sample_chan_b, rx_bit_chan_b;
  logic [6:0] parallel_input_pins, src;
  logic [7:0] parallel_output_pins;
  logic [1:0] chan_active;
  reg_sel_type register_select;
  byte_type data_in, data_out, chan_status_a, chan_status_b, rdv;
  int num_errors = 0, n_tests = 0, cyc = 0, ticks = 0;
  assign {break_chg_chan_b, rx_ready_chan_b, tx_ready_chan_b, counter_ready,
          break_chg_chan_a, rx_ready_chan_a, tx_ready_chan_a} = src;
  duart_host_port_irq_inport #(.FILTER_CYCLES(FILT)) i_dut (.*);
  host_bus_model i_host (.*);
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Hang guard and tick counter
  always @(posedge clk) begin
    cyc++;
    if (counter_ext_tick) ticks++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence: table first, then the awkward cases
  initial begin
    {src, parallel_input_pins, tx_bit_chan_a, tx_bit_chan_b, serial_in_chan_b} = '0;
    {chan_status_a, chan_status_b} = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      src <= rows[i].src;
      parallel_input_pins <= rows[i].pin;
      i_host.wr(`WR_IRQ_MASK, rows[i].mask);
      i_host.rd(`RD_IRQ_STATUS, rdv);
      chk(rdv, rows[i].interrupt_status_reg);
      chk(8'(irq_n), 8'(rows[i].irq));
      i_host.rd(`RD_INPUT_PORT, rdv);
      chk(rdv, rows[i].inp);
    end
    src <= 7'h10;
    i_host.wr(`WR_OUT_CONFIG, 8'h80);
    chk(8'(parallel_output_pins[7]), 8'h00);
    i_host.wr(`WR_OUT_CONFIG, 8'h00);
    i_host.wr(`WR_OUT_SET, 8'h03, 1'b1);
    chk(parallel_output_pins, 8'hFF);
    i_host.wr(`WR_OUT_SET, 8'h03);
    chk(parallel_output_pins, 8'hFC);
    i_host.wr(`WR_OUT_CLEAR, 8'h01);
    chk(parallel_output_pins, 8'hFD);
    i_host.rd(`RD_CTR_START, rdv);
    chk(8'(counter_running), 8'h01);
    i_host.rd(`RD_CTR_STOP, rdv);
    chk(8'(counter_running), 8'h00);
    chan_status_a <= 8'h5A;
    i_host.wr(`WR_CMD_A, 8'h04);
    chk(8'(serial_out_chan_a), 8'h00);
    i_host.rd(`RD_STATUS_A, rdv);
    chk(rdv, 8'h5A);
    chan_status_b <= 8'hA5;
    i_host.wr(`WR_CMD_B, 8'h04);
    chk(8'(serial_out_chan_b), 8'h00);
    i_host.rd(`RD_STATUS_B, rdv);
    chk(rdv, 8'hA5);
    i_host.wr(`WR_AUX_CTRL, 8'h10);
    ticks = 0;
    parallel_input_pins <= 7'h04;
    repeat (8) @(posedge clk);
    chk(8'(ticks), 8'h01);
    i_host.wr(`WR_CLK_SEL_B, 8'hE0);
    parallel_input_pins <= 7'h44;
    repeat (8) @(posedge clk);
    chk(8'(rx_bit_chan_b), 8'h00);
    i_host.rd(`RD_INPUT_CHANGE, rdv);
    i_host.rd(`RD_INPUT_CHANGE, rdv);
    chk(rdv, 8'h04);
    parallel_input_pins <= 7'h45;
    repeat (FILT + 6) @(posedge clk);
    i_host.rd(`RD_INPUT_CHANGE, rdv);
    chk(rdv, 8'h15);
    parallel_input_pins <= 7'h47;
    repeat (3) @(posedge clk);
    parallel_input_pins <= 7'h45;
    repeat (FILT + 6) @(posedge clk);
    i_host.rd(`RD_INPUT_CHANGE, rdv);
    chk(rdv, 8'h05);
    i_host.wr(`WR_AUX_CTRL, 8'h01);
    i_host.wr(`WR_IRQ_MASK, 8'h80);
    src <= 7'h00;
    parallel_input_pins <= 7'h44;
    repeat (FILT + 6) @(posedge clk);
    chk(8'(irq_n), 8'h00);
    i_host.rd(`RD_INPUT_CHANGE, rdv);
    repeat (4) @(posedge clk);
    chk(8'(irq_n), 8'h01);
    // Mid-run reset with everything busy
    i_host.wr(`WR_IRQ_MASK, 8'h01);
    src <= 7'h01;
    i_host.rd(`RD_CTR_START, rdv);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(parallel_output_pins, 8'hFF);
    chk(8'(irq_n), 8'h01);
    chk(8'({chan_active, serial_out_chan_a}), 8'h01);
    results();
  end
endmodule
`default_nettype wire
